// [rtl/lns_lin_setup.sv]
`timescale 1ns/1ps
module lns_lin_setup (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        lin_rx,
   output logic             baud_tick,
   output logic             node_master,
   output logic             auto_baud_select,
   output logic             cksum_enhanced,
   output logic             irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic                          mode_master;
      logic                          mode_auto;
      logic [7:0]                    ind_addr;
      logic [8:0]                    div;
      logic [1:0]                    pre;
      logic [4:0]                    mul;
      logic                          enh;
      logic                          run;
      logic [lns_pkg::EV_N-1:0]      sts;
      logic [lns_pkg::EV_N-1:0]      msk;
      logic [7:0]                    ck_sum;
      logic                          aw_got;
      logic                          w_got;
      logic [7:0]                    waddr;
      logic [31:0]                   wdata;
      logic [3:0]                    wstrb;
      logic                          aw_rdy;
      logic                          w_rdy;
      logic                          bvalid;
      logic [1:0]                    bresp;
      logic                          ar_rdy;
      logic                          rvalid;
      logic [31:0]                   rdata;
      logic [1:0]                    rresp;
      logic [3:0]                    pc;
      logic [8:0]                    dc;
      logic [4:0]                    mc;
      logic                          tick;
      logic                          rx_s1;
      logic                          rx_s2;
      logic                          rx_s3;
      logic                          rx_lvl;
      logic                          irq;
   } lns_state_t;

   lns_state_t q_r;
   lns_state_t q_nxt;
   logic       wr_fire;
   logic [7:0] ind_val;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] lns_ckadd(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   function automatic logic [8:0] lns_clamp_div(input logic [8:0] v);
      return (v < lns_pkg::DIV_MIN) ? lns_pkg::DIV_MIN : v;
   endfunction

   function automatic logic [7:0] lns_ind_read(input lns_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (s.ind_addr == lns_pkg::IDX_DIVL) begin
         v = s.div[7:0];
      end else if (s.ind_addr == lns_pkg::IDX_MULT) begin
         v = {s.pre, s.mul, s.div[8]};
      end else if (s.ind_addr == lns_pkg::IDX_CFG) begin
         v = {6'h00, s.run, s.enh};
      end else if (s.ind_addr == lns_pkg::IDX_STS) begin
         v = {5'h00, s.sts};
      end else if (s.ind_addr == lns_pkg::IDX_MSK) begin
         v = {5'h00, s.msk};
      end else if (s.ind_addr == lns_pkg::IDX_STATE) begin
         v = {4'h0, s.rx_lvl, s.run, s.mode_auto & ~s.mode_master, s.mode_master};
      end else if (s.ind_addr == lns_pkg::IDX_CKSUM) begin
         v = ~s.ck_sum;
      end
      return v;
   endfunction

   assign wr_fire = q_r.aw_got && q_r.w_got && !q_r.bvalid;
   assign ind_val = lns_ind_read(q_r);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic       baud_on;
      logic [3:0] pre_lim;
      logic [7:0] wb;
      logic       rx_fall;
      q_nxt   = q_r;
      rx_fall = 1'b0;
      baud_on = 1'b0;
      pre_lim = 4'h0;
      wb      = q_r.wdata[7:0];
      q_nxt.tick = 1'b0;

      // Bus line filter: first stage feeds only the second
      q_nxt.rx_s1 = lin_rx;
      q_nxt.rx_s2 = q_r.rx_s1;
      q_nxt.rx_s3 = q_r.rx_s2;
      if (q_r.rx_s2 == q_r.rx_s3 && q_r.rx_s3 != q_r.rx_lvl) begin
         q_nxt.rx_lvl = q_r.rx_s3;
         rx_fall      = !q_r.rx_s3;
      end

      // Write address and data, in either order
      if (q_r.aw_rdy && s_axi_awvalid) begin
         q_nxt.aw_got = 1'b1;
         q_nxt.waddr  = s_axi_awaddr;
      end
      if (q_r.w_rdy && s_axi_wvalid) begin
         q_nxt.w_got = 1'b1;
         q_nxt.wdata = s_axi_wdata;
         q_nxt.wstrb = s_axi_wstrb;
      end
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      if (wr_fire) begin
         q_nxt.aw_got = 1'b0;
         q_nxt.w_got  = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp  = lns_pkg::RESP_OKAY;
         if (q_r.waddr == lns_pkg::OFF_CTRL) begin
            if (q_r.wstrb[0]) begin
               q_nxt.mode_master = wb[lns_pkg::CTRL_MASTER_BIT];
               q_nxt.mode_auto   = wb[lns_pkg::CTRL_AUTO_BIT];
               // Autobaud on a master is flagged; the generator ignores it, but auto_baud_select still shows it
               if (wb[lns_pkg::CTRL_MASTER_BIT] && wb[lns_pkg::CTRL_AUTO_BIT]) begin
                  q_nxt.sts[lns_pkg::EV_CFG] = 1'b1;
               end
            end
         end else if (q_r.waddr == lns_pkg::OFF_IADDR) begin
            if (q_r.wstrb[0]) begin
               q_nxt.ind_addr = wb;
            end
         end else if (q_r.waddr == lns_pkg::OFF_IDATA) begin
            // Data port acts on selected register
            if (q_r.wstrb[0]) begin
               if (q_r.ind_addr == lns_pkg::IDX_DIVL) begin
                  // Divider held at 200 or above
                  q_nxt.div = lns_clamp_div({q_r.div[8], wb});
               end else if (q_r.ind_addr == lns_pkg::IDX_MULT) begin
                  q_nxt.pre = wb[lns_pkg::MULT_PRE_LO +: 2];
                  q_nxt.mul = wb[lns_pkg::MULT_MUL_LO +: 5];
                  q_nxt.div = lns_clamp_div({wb[lns_pkg::MULT_DIV8], q_r.div[7:0]});
               end else if (q_r.ind_addr == lns_pkg::IDX_CFG) begin
                  q_nxt.enh = wb[lns_pkg::CFG_ENH_BIT];
                  q_nxt.run = wb[lns_pkg::CFG_RUN_BIT];
               end else if (q_r.ind_addr == lns_pkg::IDX_STS) begin
                  // Clear by one; events set further down still win
                  q_nxt.sts = q_nxt.sts & ~wb[lns_pkg::EV_N-1:0];
               end else if (q_r.ind_addr == lns_pkg::IDX_MSK) begin
                  q_nxt.msk = wb[lns_pkg::EV_N-1:0];
               end else if (q_r.ind_addr == lns_pkg::IDX_PID) begin
                  // Enhanced sum starts with the identifier
                  q_nxt.ck_sum = q_r.enh ? lns_ckadd(8'h00, wb) : 8'h00;
               end else if (q_r.ind_addr == lns_pkg::IDX_DATA) begin
                  q_nxt.ck_sum = lns_ckadd(q_r.ck_sum, wb);
               end
            end
         end else begin
            q_nxt.bresp = lns_pkg::RESP_SLVERR;
         end
      end

      // Read channel
      if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      if (q_r.ar_rdy && s_axi_arvalid) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp  = lns_pkg::RESP_OKAY;
         q_nxt.rdata  = 32'h0000_0000;
         if (s_axi_araddr == lns_pkg::OFF_CTRL) begin
            q_nxt.rdata[lns_pkg::CTRL_MASTER_BIT] = q_r.mode_master;
            q_nxt.rdata[lns_pkg::CTRL_AUTO_BIT]   = q_r.mode_auto;
         end else if (s_axi_araddr == lns_pkg::OFF_IADDR) begin
            q_nxt.rdata[7:0] = q_r.ind_addr;
         end else if (s_axi_araddr == lns_pkg::OFF_IDATA) begin
            q_nxt.rdata[7:0] = ind_val;
         end else begin
            q_nxt.rresp = lns_pkg::RESP_SLVERR;
         end
      end

      // Manual generator idles while a slave runs autobaud
      baud_on = q_r.run && (q_r.mode_master || !q_r.mode_auto);
      pre_lim = 4'((5'h02 << q_r.pre) - 5'h01);
      if (baud_on) begin
         q_nxt.pc = q_r.pc + 4'h1;
         if (q_r.pc >= pre_lim) begin
            q_nxt.pc = 4'h0;
            q_nxt.dc = q_r.dc + 9'h001;
            if (q_r.dc >= q_r.div - 9'h001) begin
               q_nxt.dc = 9'h000;
               q_nxt.mc = q_r.mc + 5'h01;
               if (q_r.mc >= q_r.mul) begin
                  q_nxt.mc   = 5'h00;
                  q_nxt.tick = 1'b1;
                  q_nxt.sts[lns_pkg::EV_TICK] = 1'b1;
               end
            end
         end
      end else begin
         q_nxt.pc = 4'h0;
         q_nxt.dc = 9'h000;
         q_nxt.mc = 5'h00;
      end

      // Bus activity flag, after the clear so a set wins
      if (rx_fall) begin
         q_nxt.sts[lns_pkg::EV_RX] = 1'b1;
      end

      q_nxt.aw_rdy = !q_nxt.aw_got && !q_nxt.bvalid;
      q_nxt.w_rdy  = !q_nxt.w_got && !q_nxt.bvalid;
      q_nxt.ar_rdy = !q_nxt.rvalid;
      q_nxt.irq    = |(q_nxt.sts & q_nxt.msk);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r        <= '0;
         q_r.div    <= lns_pkg::DIV_RST;
         q_r.pre    <= lns_pkg::PRE_RST;
         q_r.mul    <= lns_pkg::MUL_RST;
         q_r.rx_s1  <= 1'b1;
         q_r.rx_s2  <= 1'b1;
         q_r.rx_s3  <= 1'b1;
         q_r.rx_lvl <= 1'b1;
      end else if (ce) begin
         q_r <= q_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready    = q_r.aw_rdy;
   assign s_axi_wready     = q_r.w_rdy;
   assign s_axi_bvalid     = q_r.bvalid;
   assign s_axi_bresp      = q_r.bresp;
   assign s_axi_arready    = q_r.ar_rdy;
   assign s_axi_rvalid     = q_r.rvalid;
   assign s_axi_rdata      = q_r.rdata;
   assign s_axi_rresp      = q_r.rresp;
   assign baud_tick        = q_r.tick;
   // Role straight from the mode bit
   assign node_master      = q_r.mode_master;
   assign auto_baud_select = q_r.mode_auto;
   assign cksum_enhanced   = q_r.enh;
   assign irq              = q_r.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [31:0] gap_r;
   logic        gap_ok_r;
   logic [31:0] period;
   assign period = (32'h0000_0002 << q_r.pre) * {23'h00_0000, q_r.div}
                   * ({27'h000_0000, q_r.mul} + 32'h0000_0001);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r    <= 32'h0000_0000;
         gap_ok_r <= 1'b0;
      end else if (ce) begin
         gap_r    <= q_r.tick ? 32'h0000_0001 : gap_r + 32'h0000_0001;
         if (wr_fire || !q_r.run) begin
            gap_ok_r <= 1'b0;
         end else if (q_r.tick) begin
            gap_ok_r <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !ce);

   sequence s_wr_ctrl;
      wr_fire && q_r.waddr == lns_pkg::OFF_CTRL && q_r.wstrb[0];
   endsequence
   sequence s_wr_ind(logic [7:0] idx);
      wr_fire && q_r.waddr == lns_pkg::OFF_IDATA && q_r.wstrb[0] && q_r.ind_addr == idx;
   endsequence
   sequence s_rx_fall;
      q_r.rx_s2 == q_r.rx_s3 && q_r.rx_lvl && !q_r.rx_s3;
   endsequence

   a_role_from_write: assert property (
      s_wr_ctrl |=> node_master == $past(q_r.wdata[lns_pkg::CTRL_MASTER_BIT]))
      else $error("role bit not taken from control write");
   a_auto_from_write: assert property (
      s_wr_ctrl |=> auto_baud_select == $past(q_r.wdata[lns_pkg::CTRL_AUTO_BIT]))
      else $error("autobaud bit not taken from control write");
   a_auto_stops_tick: assert property (
      (q_r.mode_auto && !q_r.mode_master) [*2] |-> !baud_tick)
      else $error("manual ticks while slave autobaud selected");
   a_baud_period_exact: assert property (
      (baud_tick && gap_ok_r) |-> gap_r == period)
      else $error("bit period differs from timing factors");
   a_divider_in_range: assert property (
      s_wr_ind(lns_pkg::IDX_DIVL) |=> q_r.div >= lns_pkg::DIV_MIN)
      else $error("divider below its lower limit");
   a_indirect_read_path: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == lns_pkg::OFF_IDATA)
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(ind_val))
      else $error("data port read not from selected register");
   a_unmapped_slverr: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr > lns_pkg::OFF_IDATA)
      |=> s_axi_rvalid && s_axi_rresp == lns_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
   a_cksum_seed_mode: assert property (
      s_wr_ind(lns_pkg::IDX_PID)
      |=> q_r.ck_sum == ($past(q_r.enh) ? $past(q_r.wdata[7:0]) : 8'h00))
      else $error("checksum seed wrong for selected type");
   a_rx_fall_flag: assert property (
      s_rx_fall |=> q_r.sts[lns_pkg::EV_RX] ##1 (irq || !q_r.msk[lns_pkg::EV_RX]))
      else $error("bus activity not flagged");
   a_irq_follows_sts: assert property (
      irq == |(q_r.sts & q_r.msk))
      else $error("interrupt line disagrees with status and mask");
endmodule

// [common/lns_pkg.sv]
package lns_pkg;
   // ----------------------------------------
   // Direct register byte offsets
   // ----------------------------------------
   localparam int         AXI_AW     = 8;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_IADDR  = 8'h04;
   localparam logic [7:0] OFF_IDATA  = 8'h08;
   localparam int         CTRL_MASTER_BIT = 6;
   localparam int         CTRL_AUTO_BIT   = 5;
   // ----------------------------------------
   // Indirect register indices
   // ----------------------------------------
   localparam logic [7:0] IDX_DIVL   = 8'h00;
   localparam logic [7:0] IDX_MULT   = 8'h01;
   localparam logic [7:0] IDX_CFG    = 8'h02;
   localparam logic [7:0] IDX_STS    = 8'h03;
   localparam logic [7:0] IDX_MSK    = 8'h04;
   localparam logic [7:0] IDX_STATE  = 8'h05;
   localparam logic [7:0] IDX_PID    = 8'h06;
   localparam logic [7:0] IDX_DATA   = 8'h07;
   localparam logic [7:0] IDX_CKSUM  = 8'h08;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int MULT_PRE_LO  = 6;
   localparam int MULT_MUL_LO  = 1;
   localparam int MULT_DIV8    = 0;
   localparam int CFG_ENH_BIT  = 0;
   localparam int CFG_RUN_BIT  = 1;
   localparam int EV_TICK      = 0;
   localparam int EV_RX        = 1;
   localparam int EV_CFG       = 2;
   localparam int EV_N         = 3;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [8:0] DIV_MIN    = 9'h0C8;
   localparam logic [8:0] DIV_RST    = 9'h0C8;
   localparam logic [1:0] PRE_RST    = 2'h0;
   localparam logic [4:0] MUL_RST    = 5'h00;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         CLK_MHZ    = 100;
   localparam int         MIN_SYSTEM_CLOCK_MHZ = 8;
endpackage

// [test/lns_lin_peer.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far-side LIN node: drives a dominant break
// ----------------------------------------
module lns_lin_peer (
   input  wire logic        aclk,
   input  wire logic        send_break,
   input  wire logic [15:0] break_len,
   output logic             lin_rx
);
   logic [15:0] cnt_r = 16'h0000;
   // Released bus floats to the pull-up level
   assign lin_rx = (cnt_r == 16'h0000);
   always @(posedge aclk) begin
      if (send_break && cnt_r == 16'h0000) begin
         cnt_r <= break_len;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   logic        aclk    = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr  = 8'h00;
   logic        awvalid = 1'h0;
   logic [31:0] wdata   = 32'h0000_0000;
   logic [3:0]  wstrb   = 4'h0;
   logic        wvalid  = 1'h0;
   logic        bready  = 1'h0;
   logic [7:0]  araddr  = 8'h00;
   logic        arvalid = 1'h0;
   logic        rready  = 1'h0;
   logic        brk     = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, lin_rx;
   logic        baud_tick, node_master, auto_baud_select, cksum_enhanced, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          fail_count = 0;
   int          tests_run  = 0;

   // 100 MHz, well above the 8 MHz floor
   always #5 aclk = ~aclk;

   lns_lin_setup dut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lin_rx(lin_rx), .baud_tick(baud_tick), .node_master(node_master),
      .auto_baud_select(auto_baud_select), .cksum_enhanced(cksum_enhanced), .irq(irq));
   lns_lin_peer peer (.aclk(aclk), .send_break(brk), .break_len(16'h0014), .lin_rx(lin_rx));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic gb;
      n = 0;
      gb = 1'h0;
      r = 2'h3;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'h1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      // No local limit: only the watchdog ends a hung wait
      while (!gb) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) begin
            awvalid <= 1'h0;
         end
         if (wvalid && wready) begin
            wvalid <= 1'h0;
         end
         if (bvalid) begin
            gb = 1'h1;
            r = bresp;
            bready <= 1'h0;
         end
      end
      `CHK("write_latency", 3, n)
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic gr;
      n = 0;
      gr = 1'h0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      while (!gr) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'h0;
         end
         if (rvalid) begin
            gr = 1'h1;
            d = rdata;
            r = rresp;
            rready <= 1'h0;
         end
      end
      `CHK("read_latency", 2, n)
   endtask
   task automatic ind_wr(input logic [7:0] i, input logic [7:0] v);
      logic [1:0] r;
      axi_wr(lns_pkg::OFF_IADDR, {24'h00_0000, i}, r);
      axi_wr(lns_pkg::OFF_IDATA, {24'h00_0000, v}, r);
      `CHK("ind_wr_resp", lns_pkg::RESP_OKAY, r)
   endtask
   task automatic ind_rd(input logic [7:0] i, output logic [31:0] v);
      logic [1:0] r;
      axi_wr(lns_pkg::OFF_IADDR, {24'h00_0000, i}, r);
      axi_rd(lns_pkg::OFF_IDATA, v, r);
      `CHK("ind_rd_resp", lns_pkg::RESP_OKAY, r)
   endtask
   task automatic measure(output int p);
      int n;
      n = 0;
      while (!baud_tick && n < 30000) begin
         @(posedge aclk);
         n++;
      end
      @(posedge aclk);
      p = 1;
      while (!baud_tick && p < 30000) begin
         @(posedge aclk);
         p++;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] v;
      logic [1:0]  r;
      axi_rd(lns_pkg::OFF_CTRL, v, r);
      `CHK("ctrl_rst", 32'h0000_0000, v)
      ind_rd(lns_pkg::IDX_DIVL, v);
      `CHK("div_rst", 32'h0000_00C8, v)
      ind_rd(lns_pkg::IDX_MULT, v);
      `CHK("mult_rst", 32'h0000_0000, v)
      `CHK("master_rst", 1'h0, node_master)
   endtask
   task automatic t_mode;
      logic [31:0] v;
      logic [1:0]  r;
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0040, r);
      `CHK("master_out", 1'h1, node_master)
      axi_rd(lns_pkg::OFF_CTRL, v, r);
      `CHK("ctrl_read", 32'h0000_0040, v)
      ind_rd(lns_pkg::IDX_STATE, v);
      `CHK("state_master", 1'h1, v[0])
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0020, r);
      `CHK("slave_out", 1'h0, node_master)
      `CHK("auto_out", 1'h1, auto_baud_select)
      // Idle line high, generator off, slave autobaud active
      ind_rd(lns_pkg::IDX_STATE, v);
      `CHK("state_slave_auto", 32'h0000_000A, v)
   endtask
   task automatic t_indirect;
      logic [31:0] v;
      logic [1:0]  r;
      ind_wr(lns_pkg::IDX_MSK, 8'h05);
      ind_rd(lns_pkg::IDX_MSK, v);
      `CHK("mask_back", 32'h0000_0005, v)
      ind_rd(lns_pkg::IDX_DIVL, v);
      `CHK("index_switch", 32'h0000_00C8, v)
      axi_wr(8'h0C, 32'h0000_00FF, r);
      `CHK("unmapped_wr", lns_pkg::RESP_SLVERR, r)
      axi_rd(8'h0C, v, r);
      `CHK("unmapped_rd", lns_pkg::RESP_SLVERR, r)
      ind_wr(lns_pkg::IDX_MSK, 8'h00);
   endtask
   task automatic t_baud;
      int          pre[4] = '{0, 1, 2, 0};
      int          mul[4] = '{0, 1, 0, 0};
      int          dv[4]  = '{200, 201, 511, 100};
      int          ex[4]  = '{400, 1608, 4088, 400};
      int          p;
      int          n;
      logic [8:0]  d;
      logic [31:0] v;
      logic [1:0]  r;
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0040, r);
      for (int i = 0; i < 4; i++) begin
         d = dv[i][8:0];
         ind_wr(lns_pkg::IDX_CFG, 8'h00);
         ind_wr(lns_pkg::IDX_DIVL, d[7:0]);
         ind_wr(lns_pkg::IDX_MULT, {pre[i][1:0], mul[i][4:0], d[8]});
         ind_wr(lns_pkg::IDX_CFG, 8'h02);
         measure(p);
         `CHK("bit_period", ex[i], p)
      end
      ind_rd(lns_pkg::IDX_DIVL, v);
      `CHK("div_clamp", 32'h0000_00C8, v)
      ind_rd(lns_pkg::IDX_STS, v);
      `CHK("tick_status", 1'h1, v[0])
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0020, r);
      // Five periods of the last setting, with no tick allowed
      n = 0;
      repeat (2000) begin
         @(posedge aclk);
         if (baud_tick) begin
            n++;
         end
      end
      `CHK("auto_stops_gen", 0, n)
      ind_wr(lns_pkg::IDX_CFG, 8'h00);
   endtask
   task automatic t_cksum;
      logic [31:0] v;
      logic [1:0]  r;
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0000, r);
      ind_wr(lns_pkg::IDX_PID, 8'h3C);
      ind_wr(lns_pkg::IDX_DATA, 8'h01);
      ind_wr(lns_pkg::IDX_DATA, 8'h02);
      ind_rd(lns_pkg::IDX_CKSUM, v);
      `CHK("classic_sum", 32'h0000_00FC, v)
      `CHK("classic_out", 1'h0, cksum_enhanced)
      ind_wr(lns_pkg::IDX_CFG, 8'h01);
      ind_wr(lns_pkg::IDX_PID, 8'h80);
      ind_wr(lns_pkg::IDX_DATA, 8'h90);
      ind_rd(lns_pkg::IDX_CKSUM, v);
      `CHK("enhanced_sum", 32'h0000_00EE, v)
      `CHK("enhanced_out", 1'h1, cksum_enhanced)
   endtask
   task automatic t_irq;
      logic [31:0] v;
      logic [1:0]  r;
      ind_wr(lns_pkg::IDX_STS, 8'h07);
      ind_wr(lns_pkg::IDX_MSK, 8'h02);
      `CHK("irq_idle", 1'h0, irq)
      @(posedge aclk) brk <= 1'h1;
      @(posedge aclk) brk <= 1'h0;
      repeat (40) @(posedge aclk);
      `CHK("irq_set", 1'h1, irq)
      ind_wr(lns_pkg::IDX_STS, 8'h02);
      `CHK("irq_clear", 1'h0, irq)
      ind_wr(lns_pkg::IDX_MSK, 8'h00);
      @(posedge aclk) brk <= 1'h1;
      @(posedge aclk) brk <= 1'h0;
      repeat (40) @(posedge aclk);
      `CHK("irq_masked", 1'h0, irq)
      ind_rd(lns_pkg::IDX_STS, v);
      `CHK("poll_edge", 1'h1, v[1])
      axi_wr(lns_pkg::OFF_CTRL, 32'h0000_0060, r);
      ind_rd(lns_pkg::IDX_STS, v);
      `CHK("cfg_error", 1'h1, v[2])
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Whole run is about 15500 cycles, mostly the baud table
   initial begin
      #400000;
      fail_count++;
      $display("mismatch watchdog expected 0 seen 1");
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_mode();
      t_indirect();
      t_baud();
      t_cksum();
      t_irq();
      tally_and_finish();
   end
endmodule
